// file: design/dtd_pkg.sv
// Package of opcode patterns, field positions and decoded-operation carriers for the data transfer decoder
package dtd_pkg;

    // Field positions inside a 16-bit instruction
    localparam int DEST_MSB      = 11;
    localparam int DEST_LSB      = 8;
    localparam int SRC_MSB       = 7;
    localparam int SRC_LSB       = 4;
    localparam int DISP4_MSB     = 3;
    localparam int DISP8_MSB     = 7;

    // Major opcode nibbles (bits 15:12)
    localparam logic [3:0] OP_IMM       = 4'hE;
    localparam logic [3:0] OP_PCW       = 4'h9;
    localparam logic [3:0] OP_PCL       = 4'hD;
    localparam logic [3:0] OP_GRP6      = 4'h6;
    localparam logic [3:0] OP_GRP2      = 4'h2;
    localparam logic [3:0] OP_GRP8      = 4'h8;
    localparam logic [3:0] OP_STDL      = 4'h1;
    localparam logic [3:0] OP_LDDL      = 4'h5;
    localparam logic [3:0] OP_GRP0      = 4'h0;

    // Minor codes (bits 3:0 or 11:8)
    localparam logic [3:0] SUB_LD_B     = 4'h0;
    localparam logic [3:0] SUB_LD_W     = 4'h1;
    localparam logic [3:0] SUB_LD_L     = 4'h2;
    localparam logic [3:0] SUB_MOVE     = 4'h3;
    localparam logic [3:0] SUB_PI_B     = 4'h4;
    localparam logic [3:0] SUB_PI_W     = 4'h5;
    localparam logic [3:0] SUB_PI_L     = 4'h6;
    localparam logic [3:0] SUB_ST_B     = 4'h0;
    localparam logic [3:0] SUB_ST_W     = 4'h1;
    localparam logic [3:0] SUB_ST_L     = 4'h2;
    localparam logic [3:0] SUB_PD_B     = 4'h4;
    localparam logic [3:0] SUB_PD_W     = 4'h5;
    localparam logic [3:0] SUB_PD_L     = 4'h6;
    localparam logic [3:0] SUB_STD_B    = 4'h0;
    localparam logic [3:0] SUB_STD_W    = 4'h1;
    localparam logic [3:0] SUB_LDD_B    = 4'h4;
    localparam logic [3:0] SUB_LDD_W    = 4'h5;
    localparam logic [3:0] SUB_IX_B     = 4'h4;
    localparam logic [3:0] SUB_IX_W     = 4'h5;

    // Register index of the implicit index register
    localparam logic [3:0] REG_ZERO     = 4'h0;

    // Minimum execution cycles of every transfer here
    localparam int MIN_EXEC_CYCLES      = 1;

    // Operand size
    typedef enum logic [1:0] {
        DTD_SZ_BYTE = 2'h0,
        DTD_SZ_HALF = 2'h1,
        DTD_SZ_LONG = 2'h2
    } dtd_size_e;

    // Address base selection
    typedef enum logic [2:0] {
        DTD_BASE_NONE = 3'h0,
        DTD_BASE_PC   = 3'h1,
        DTD_BASE_DEST = 3'h2,
        DTD_BASE_SRC  = 3'h3,
        DTD_BASE_IDX  = 3'h4
    } dtd_base_e;

    // Operation class
    typedef enum logic [2:0] {
        DTD_OP_NONE  = 3'h0,
        DTD_OP_IMM   = 3'h1,
        DTD_OP_MOVE  = 3'h2,
        DTD_OP_LOAD  = 3'h3,
        DTD_OP_STORE = 3'h4
    } dtd_op_e;

    // Decoded instruction handed to the execution stage
    typedef struct packed {
        logic        valid;
        dtd_op_e     op;
        dtd_size_e   size;
        logic [3:0]  dest_reg;
        logic [3:0]  source_reg;
        logic [3:0]  data_reg;
        logic [3:0]  addr_reg;
        dtd_base_e   base;
        logic        add_index_reg_zero;
        logic [31:0] offset;
        logic [31:0] imm;
        logic        sign_extend;
        logic        pre_dec;
        logic        post_inc;
        logic        illegal;
    } dtd_uop_s;

endpackage : dtd_pkg

// file: design/dtd_field_scale.sv
// Displacement scaler: zero-extends a displacement field and multiplies it by the operand size
`timescale 1ns/1ps

module dtd_field_scale #(
    parameter int DW = 8
) (
    input  wire logic [DW-1:0]       disp,
    input  wire dtd_pkg::dtd_size_e  size,
    output logic [31:0]              scaled
);

    logic [31:0] wide;

    assign wide = {{(32-DW){1'b0}}, disp};

    // Shift by size: x1, x2, x4
    always_comb begin
        case (size)
            dtd_pkg::DTD_SZ_BYTE: scaled = wide;
            dtd_pkg::DTD_SZ_HALF: scaled = {wide[30:0], 1'b0};
            dtd_pkg::DTD_SZ_LONG: scaled = {wide[29:0], 2'b00};
            default:              scaled = wide;
        endcase
    end

endmodule // dtd_field_scale

// file: design/dtd_decoder.sv
// Data transfer instruction decoder with load-use and fetch-contention stall control
//
// Operation
// - Register fields are 4-bit binary indices, 0000 is register 0, 1111 register 15.
// - Displacements scale by one, two or four per byte, word, longword size.
// - 1110nnnniiiiiiii loads sign-extended 8-bit immediate into dest_reg.
// - 1001 loads sign-extended word from PC plus twice displacement.
// - 1101 loads longword from PC plus four times displacement.
// - 0110 codes 0000-0010 load at source_reg address, byte/word sign-extended.
// - 0010 codes 0100-0110 decrement dest_reg by size, then store source_reg.
// - Post-increment loads sign-extend byte/word, then advance source_reg by size.
// - 10000000/10000001 store index_reg_zero at dest_reg plus scaled displacement.
// - 0001 stores source_reg longword at dest_reg plus four times displacement.
// - 10000100/10000101 load sign-extended byte/word into index_reg_zero.
// - 0101 loads longword from source_reg plus four times displacement.
// - 0000 codes 0100/0101 store source_reg at index_reg_zero plus dest_reg.
// - Each transfer takes one cycle unless a stall applies.
// - Stall when an instruction uses the previous load's destination register.
// - Stall when instruction fetch and data access contend for memory.
// - No decoded transfer alters the true/false flag or needs privilege.
`timescale 1ns/1ps

module dtd_decoder (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              insn_valid,
    input  wire logic [15:0]       insn,
    input  wire logic              fetch_busy,
    input  wire logic              exec_ready,
    output logic                   insn_ready,
    output dtd_pkg::dtd_uop_s      uop,
    output logic                   stall,
    output logic                   tflag_write,
    output logic                   priv_required
);

    // Reset synchroniser
    logic                 rst_s1_ff;
    logic                 rst_s2_ff;
    logic                 rst_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    // Only the second stage feeds the design, so the release edge is clean on the clock
    assign rst_n = rst_s2_ff;

    // Field extraction
    logic [3:0]           f_top;
    logic [3:0]           f_dest;
    logic [3:0]           f_src;
    logic [3:0]           f_low;
    logic [7:0]           f_disp8;
    logic [3:0]           f_disp4;

    assign f_top   = insn[15:12];
    assign f_dest  = insn[dtd_pkg::DEST_MSB:dtd_pkg::DEST_LSB];
    assign f_src   = insn[dtd_pkg::SRC_MSB:dtd_pkg::SRC_LSB];
    assign f_low   = insn[3:0];
    assign f_disp8 = insn[dtd_pkg::DISP8_MSB:0];
    assign f_disp4 = insn[dtd_pkg::DISP4_MSB:0];

    // Decode outputs, the scaled offsets and the scaling size that drives the scalers
    dtd_pkg::dtd_uop_s    nxt_uop;
    logic                 use_disp8;
    logic [31:0]          scaled8;
    logic [31:0]          scaled4;
    dtd_pkg::dtd_size_e   disp_size;

    // Scaling size decoded from the opcode alone, so the scaled offsets never loop back
    // through the main decode process that reads them
    always_comb begin
        case (f_top)
            dtd_pkg::OP_PCW:  disp_size = dtd_pkg::DTD_SZ_HALF;
            dtd_pkg::OP_GRP8: disp_size = insn[8] ? dtd_pkg::DTD_SZ_HALF : dtd_pkg::DTD_SZ_BYTE;
            dtd_pkg::OP_PCL, dtd_pkg::OP_STDL, dtd_pkg::OP_LDDL: disp_size = dtd_pkg::DTD_SZ_LONG;
            default:          disp_size = dtd_pkg::DTD_SZ_BYTE;
        endcase
    end

    dtd_field_scale #(.DW(8)) u_scale8 (
        .disp   (f_disp8),
        .size   (disp_size),
        .scaled (scaled8)
    );

    dtd_field_scale #(.DW(4)) u_scale4 (
        .disp   (f_disp4),
        .size   (disp_size),
        .scaled (scaled4)
    );

    // Combinational decode of one instruction
    always_comb begin
        nxt_uop = '0;
        use_disp8 = 1'b0;
        nxt_uop.valid = 1'b1;
        nxt_uop.dest_reg = f_dest;
        nxt_uop.source_reg = f_src;
        case (f_top)
            dtd_pkg::OP_IMM: begin
                nxt_uop.op = dtd_pkg::DTD_OP_IMM;
                nxt_uop.size = dtd_pkg::DTD_SZ_LONG;
                nxt_uop.data_reg = f_dest;
                nxt_uop.imm = {{24{f_disp8[7]}}, f_disp8};
            end
            // PC-relative loads take the 8-bit displacement
            dtd_pkg::OP_PCW, dtd_pkg::OP_PCL: begin
                nxt_uop.op = dtd_pkg::DTD_OP_LOAD;
                nxt_uop.data_reg = f_dest;
                nxt_uop.base = dtd_pkg::DTD_BASE_PC;
                use_disp8 = 1'b1;
                if (f_top == dtd_pkg::OP_PCW) begin
                    nxt_uop.size = dtd_pkg::DTD_SZ_HALF;
                    nxt_uop.sign_extend = 1'b1;
                end else begin
                    nxt_uop.size = dtd_pkg::DTD_SZ_LONG;
                end
            end
            // Group 6 addresses through the source field and writes the destination field
            dtd_pkg::OP_GRP6: begin
                nxt_uop.data_reg = f_dest;
                nxt_uop.addr_reg = f_src;
                case (f_low)
                    dtd_pkg::SUB_LD_B, dtd_pkg::SUB_LD_W, dtd_pkg::SUB_LD_L: begin
                        nxt_uop.op = dtd_pkg::DTD_OP_LOAD;
                        nxt_uop.base = dtd_pkg::DTD_BASE_SRC;
                        nxt_uop.size = dtd_pkg::dtd_size_e'(f_low[1:0]);
                        nxt_uop.sign_extend = (f_low != dtd_pkg::SUB_LD_L);
                    end
                    dtd_pkg::SUB_PI_B, dtd_pkg::SUB_PI_W, dtd_pkg::SUB_PI_L: begin
                        nxt_uop.op = dtd_pkg::DTD_OP_LOAD;
                        nxt_uop.base = dtd_pkg::DTD_BASE_SRC;
                        nxt_uop.size = dtd_pkg::dtd_size_e'(2'(f_low[1:0] - 2'h0));
                        nxt_uop.sign_extend = (f_low != dtd_pkg::SUB_PI_L);
                        nxt_uop.post_inc = 1'b1;
                    end
                    dtd_pkg::SUB_MOVE: begin
                        nxt_uop.op = dtd_pkg::DTD_OP_MOVE;
                        nxt_uop.size = dtd_pkg::DTD_SZ_LONG;
                    end
                    default: nxt_uop.illegal = 1'b1;
                endcase
            end
            // Group 2 addresses through the destination field and stores the source field
            dtd_pkg::OP_GRP2: begin
                nxt_uop.op = dtd_pkg::DTD_OP_STORE;
                nxt_uop.data_reg = f_src;
                nxt_uop.addr_reg = f_dest;
                nxt_uop.base = dtd_pkg::DTD_BASE_DEST;
                case (f_low)
                    dtd_pkg::SUB_ST_B, dtd_pkg::SUB_ST_W, dtd_pkg::SUB_ST_L: begin
                        nxt_uop.size = dtd_pkg::dtd_size_e'(f_low[1:0]);
                    end
                    dtd_pkg::SUB_PD_B, dtd_pkg::SUB_PD_W, dtd_pkg::SUB_PD_L: begin
                        nxt_uop.size = dtd_pkg::dtd_size_e'(f_low[1:0]);
                        nxt_uop.pre_dec = 1'b1;
                    end
                    default: begin
                        nxt_uop.op = dtd_pkg::DTD_OP_NONE;
                        nxt_uop.illegal = 1'b1;
                    end
                endcase
            end
            // Bits 11:8 pick the form here; bits 7:4 name the base register
            dtd_pkg::OP_GRP8: begin
                nxt_uop.data_reg = dtd_pkg::REG_ZERO;
                nxt_uop.size = insn[8] ? dtd_pkg::DTD_SZ_HALF : dtd_pkg::DTD_SZ_BYTE;
                case (f_dest)
                    dtd_pkg::SUB_STD_B, dtd_pkg::SUB_STD_W: begin
                        nxt_uop.op = dtd_pkg::DTD_OP_STORE;
                        nxt_uop.addr_reg = f_src;
                        nxt_uop.dest_reg = f_src;
                        nxt_uop.base = dtd_pkg::DTD_BASE_DEST;
                    end
                    dtd_pkg::SUB_LDD_B, dtd_pkg::SUB_LDD_W: begin
                        nxt_uop.op = dtd_pkg::DTD_OP_LOAD;
                        nxt_uop.addr_reg = f_src;
                        nxt_uop.dest_reg = dtd_pkg::REG_ZERO;
                        nxt_uop.base = dtd_pkg::DTD_BASE_SRC;
                        nxt_uop.sign_extend = 1'b1;
                    end
                    default: nxt_uop.illegal = 1'b1;
                endcase
            end
            dtd_pkg::OP_STDL: begin
                nxt_uop.op = dtd_pkg::DTD_OP_STORE;
                nxt_uop.size = dtd_pkg::DTD_SZ_LONG;
                nxt_uop.data_reg = f_src;
                nxt_uop.addr_reg = f_dest;
                nxt_uop.base = dtd_pkg::DTD_BASE_DEST;
            end
            dtd_pkg::OP_LDDL: begin
                nxt_uop.op = dtd_pkg::DTD_OP_LOAD;
                nxt_uop.size = dtd_pkg::DTD_SZ_LONG;
                nxt_uop.data_reg = f_dest;
                nxt_uop.addr_reg = f_src;
                nxt_uop.base = dtd_pkg::DTD_BASE_SRC;
            end
            // Only the indexed byte and word stores live in this group
            dtd_pkg::OP_GRP0: begin
                nxt_uop.data_reg = f_src;
                nxt_uop.addr_reg = f_dest;
                if (f_low == dtd_pkg::SUB_IX_B || f_low == dtd_pkg::SUB_IX_W) begin
                    nxt_uop.op = dtd_pkg::DTD_OP_STORE;
                    nxt_uop.size = f_low[0] ? dtd_pkg::DTD_SZ_HALF : dtd_pkg::DTD_SZ_BYTE;
                    nxt_uop.base = dtd_pkg::DTD_BASE_IDX;
                    nxt_uop.add_index_reg_zero = 1'b1;
                end else begin
                    nxt_uop.illegal = 1'b1;
                end
            end
            default: nxt_uop.illegal = 1'b1;
        endcase
        // Only displacement forms carry an offset; others leave it zero
        if (use_disp8) begin
            nxt_uop.offset = scaled8;
        end else if (f_top == dtd_pkg::OP_GRP8 || f_top == dtd_pkg::OP_STDL || f_top == dtd_pkg::OP_LDDL) begin
            nxt_uop.offset = scaled4;
        end
        if (nxt_uop.illegal) begin
            nxt_uop.op = dtd_pkg::DTD_OP_NONE;
        end
    end

    // Destination of the previous load, kept for the load-use check
    logic                 last_load_ff;
    logic [3:0]           last_load_reg_ff;
    logic                 hazard;
    logic                 contend;
    logic                 advance;

    // Registers the incoming instruction reads; a load is recorded by its data register only, though a post-increment load also writes its source field,
    // and a move reads its source field, which the data register does not name
    logic                 rd_data;
    logic                 rd_addr;
    logic                 rd_move;
    logic                 rd_index;

    always_comb begin
        rd_data  = nxt_uop.op == dtd_pkg::DTD_OP_STORE && nxt_uop.data_reg == last_load_reg_ff;
        rd_addr  = nxt_uop.base != dtd_pkg::DTD_BASE_NONE && nxt_uop.base != dtd_pkg::DTD_BASE_PC &&
                   nxt_uop.addr_reg == last_load_reg_ff;
        rd_move  = nxt_uop.op == dtd_pkg::DTD_OP_MOVE && nxt_uop.source_reg == last_load_reg_ff;
        rd_index = nxt_uop.add_index_reg_zero && last_load_reg_ff == dtd_pkg::REG_ZERO;
    end

    assign hazard = last_load_ff && insn_valid && !nxt_uop.illegal &&
                    (rd_data || rd_addr || rd_move || rd_index);
    // A data access is held back for as long as a fetch holds memory
    // Immediates and moves never touch memory, so they pass a busy fetch
    assign contend = insn_valid && fetch_busy &&
                     (nxt_uop.op == dtd_pkg::DTD_OP_LOAD || nxt_uop.op == dtd_pkg::DTD_OP_STORE);
    assign advance = insn_valid && exec_ready && !hazard && !contend;

    // Load-use tracking: a stall bubble clears the record so the stall lasts one cycle
    // A held-up execute stage keeps the record, so the bubble still lands after it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_load_ff <= 1'b0;
            last_load_reg_ff <= 4'h0;
        end else if (advance) begin
            last_load_ff <= (nxt_uop.op == dtd_pkg::DTD_OP_LOAD);
            last_load_reg_ff <= nxt_uop.data_reg;
        end else if (exec_ready) begin
            last_load_ff <= 1'b0;
        end
    end

    // Registered decode output, one instruction per cycle when no stall
    // Holding the uop while execution is busy keeps the operation stable until it is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uop <= '0;
        end else if (exec_ready) begin
            uop <= advance ? nxt_uop : '0;
        end
    end

    // Handshake and stall status
    // The flag and privilege outputs stay low: nothing here touches the status word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            insn_ready <= 1'b0;
            stall <= 1'b0;
            tflag_write <= 1'b0;
            priv_required <= 1'b0;
        end else begin
            insn_ready <= advance;
            stall <= hazard || contend;
            tflag_write <= 1'b0;
            priv_required <= 1'b0;
        end
    end

endmodule // dtd_decoder

// file: tb/dtd_decoder_props.sv
// Concurrent checks on the data transfer decoder ports
`timescale 1ns/1ps

module dtd_decoder_props (
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              insn_valid,
    input wire logic [15:0]       insn,
    input wire logic              fetch_busy,
    input wire logic              exec_ready,
    input wire logic              insn_ready,
    input wire dtd_pkg::dtd_uop_s uop,
    input wire logic              stall,
    input wire logic              tflag_write,
    input wire logic              priv_required
);
    // One clock domain; the raw reset is enough since outputs stay low until the copy releases
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_no_flag_write: assert property (!tflag_write && !priv_required)
        else $error("flag or privilege output raised");
    a_imm_sign_ext: assert property (insn_ready && $past(insn[15:12]) == 4'hE |->
        uop.op == dtd_pkg::DTD_OP_IMM && uop.data_reg == $past(insn[11:8])
        && uop.imm == {{24{$past(insn[7])}}, $past(insn[7:0])})
        else $error("immediate decode wrong");
    a_pc_word_disp: assert property (insn_ready && $past(insn[15:12]) == 4'h9 |->
        uop.base == dtd_pkg::DTD_BASE_PC && uop.size == dtd_pkg::DTD_SZ_HALF && uop.sign_extend
        && uop.offset == {23'h0, $past(insn[7:0]), 1'b0})
        else $error("pc word load decode wrong");
    a_pc_long_disp: assert property (insn_ready && $past(insn[15:12]) == 4'hD |->
        uop.base == dtd_pkg::DTD_BASE_PC && uop.size == dtd_pkg::DTD_SZ_LONG && !uop.sign_extend
        && uop.offset == {22'h0, $past(insn[7:0]), 2'h0})
        else $error("pc long load decode wrong");
    a_disp_store: assert property (insn_ready && $past(insn[15:12]) == 4'h1 |->
        uop.op == dtd_pkg::DTD_OP_STORE && uop.data_reg == $past(insn[7:4])
        && uop.addr_reg == $past(insn[11:8]) && uop.offset == {26'h0, $past(insn[3:0]), 2'h0})
        else $error("displacement store decode wrong");
    a_contention_stall: assert property (insn_valid && exec_ready && fetch_busy && insn[15:12] == 4'h1
        |=> stall && !insn_ready)
        else $error("store taken during fetch contention");
    a_load_use_stall: assert property (insn_ready && $past(insn[15:12]) == 4'h6 && $past(insn[3:0]) == 4'h2
        && insn_valid && exec_ready && insn[15:12] == 4'h2 && insn[7:4] == $past(insn[11:8]) && !insn[3]
        && insn[1:0] != 2'h3
        |=> stall && !insn_ready)
        else $error("load-use hazard not stalled");
    a_accept_next: assert property (insn_valid && exec_ready && !fetch_busy && insn[15:12] == 4'hE
        |=> insn_ready && uop.valid)
        else $error("immediate not answered in one cycle");
endmodule // dtd_decoder_props

bind dtd_decoder dtd_decoder_props dtd_decoder_props_i (.clk(clk), .reset_n(reset_n), .insn_valid(insn_valid),
    .insn(insn), .fetch_busy(fetch_busy), .exec_ready(exec_ready), .insn_ready(insn_ready), .uop(uop),
    .stall(stall), .tflag_write(tflag_write), .priv_required(priv_required));

// file: tb/dtd_fetch_model.sv
// Fetch and execute stage model offering instruction words to the decoder
`timescale 1ns/1ps

module dtd_fetch_model (
    input  wire logic   clk,
    input  wire logic   insn_ready,
    input  wire logic   stall,
    output logic        insn_valid,
    output logic [15:0] insn,
    output logic        fetch_busy,
    output logic        exec_ready
);
    initial begin
        insn_valid = 1'b0;
        insn       = 16'h0000;
        fetch_busy = 1'b0;
        exec_ready = 1'b1;
    end

    // Hold the word until taken; busy and hold counts stretch the offer to provoke refusals
    task automatic send(input logic [15:0] w, input int busy_n, input int hold_n,
                        output int waits, output logic stalled);
        waits      = 0;
        stalled    = 1'b0;
        insn_valid = 1'b1;
        insn       = w;
        fetch_busy = (busy_n > 0);
        exec_ready = (hold_n == 0);
        while (waits < 20) begin
            @(negedge clk);
            waits   = waits + 1;
            stalled = stalled | (stall === 1'b1);
            if (insn_ready === 1'b1) break;
            fetch_busy = (waits < busy_n);
            exec_ready = (waits >= hold_n);
        end
    endtask

    // Withdraw the offer; the word turns over so a stale value never looks held
    task automatic idle();
        insn_valid = 1'b0;
        insn       = ~insn;
        @(negedge clk);
    endtask
endmodule // dtd_fetch_model

// file: tb/dtd_decoder_test.sv
// Self-checking testbench for the data transfer decoder
`timescale 1ns/1ps

module dtd_decoder_test;
    localparam logic [2:0] LD = 3'(dtd_pkg::DTD_OP_LOAD);
    localparam logic [2:0] ST = 3'(dtd_pkg::DTD_OP_STORE);
    logic              clk;
    logic              reset_n;
    logic              insn_valid;
    logic [15:0]       insn;
    logic              fetch_busy;
    logic              exec_ready;
    logic              insn_ready;
    dtd_pkg::dtd_uop_s uop;
    logic              stall;
    logic              tflag_write;
    logic              priv_required;
    int                num_errors = 0;
    int                n_checks = 0;
    int                cycles = 0;
    int                waits;
    logic              stalled;

    dtd_decoder dtd_decoder_i (.clk(clk), .reset_n(reset_n), .insn_valid(insn_valid), .insn(insn),
        .fetch_busy(fetch_busy), .exec_ready(exec_ready), .insn_ready(insn_ready), .uop(uop),
        .stall(stall), .tflag_write(tflag_write), .priv_required(priv_required));
    dtd_fetch_model dtd_fetch_model_i (.clk(clk), .insn_ready(insn_ready), .stall(stall),
        .insn_valid(insn_valid), .insn(insn), .fetch_busy(fetch_busy), .exec_ready(exec_ready));

    // 250 MHz core clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic go(input logic [15:0] w, input int busy_n, input int hold_n);
        dtd_fetch_model_i.send(w, busy_n, hold_n, waits, stalled);
    endtask

    // Back-to-back immediates at both register extremes and both signs
    task automatic t_immediate();
        logic [15:0] w [4] = '{16'hE07F, 16'hEF80, 16'hE000, 16'hE5FF};
        for (int i = 0; i < 4; i++) begin
            go(w[i], 0, 0);
            check("imm reg", 32'(uop.data_reg), 32'(w[i][11:8]));
            check("imm val", uop.imm, {{24{w[i][7]}}, w[i][7:0]});
            check("imm wait", 32'(waits), 32'h1);
        end
    endtask

    // PC-relative loads with the largest and a sign-bit displacement
    task automatic t_pc();
        go(16'h93FF, 0, 0);
        check("pc word", uop.offset, 32'h000001FE);
        check("pc word reg", 32'(uop.data_reg), 32'h3);
        go(16'hDC80, 0, 0);
        check("pc long", uop.offset, 32'h00000200);
        check("pc long ext", 32'(uop.sign_extend), 32'h0);
    endtask

    // One addressing form; flags are sign extend, pre-decrement, post-increment, index add
    task automatic row(input logic [15:0] w, input logic [2:0] op, input logic [1:0] sz,
                       input logic [3:0] fl, input logic [7:0] off, input logic [3:0] ar, input logic [3:0] dr);
        go(w, 0, 0);
        check("valid", 32'(uop.valid), 32'h1);
        check("op", 32'(uop.op), 32'(op));
        check("size", 32'(uop.size), 32'(sz));
        check("flags", 32'({uop.sign_extend, uop.pre_dec, uop.post_inc, uop.add_index_reg_zero}), 32'(fl));
        check("offset", uop.offset, 32'(off));
        check("addr reg", 32'(uop.addr_reg), 32'(ar));
        check("data reg", 32'(uop.data_reg), 32'(dr));
    endtask

    task automatic t_forms();
        row(16'h6A50, LD, 2'h0, 4'h8, 8'h00, 4'h5, 4'hA);
        row(16'h6A51, LD, 2'h1, 4'h8, 8'h00, 4'h5, 4'hA);
        row(16'h6A52, LD, 2'h2, 4'h0, 8'h00, 4'h5, 4'hA);
        row(16'h6A54, LD, 2'h0, 4'hA, 8'h00, 4'h5, 4'hA);
        row(16'h6A55, LD, 2'h1, 4'hA, 8'h00, 4'h5, 4'hA);
        row(16'h6A56, LD, 2'h2, 4'h2, 8'h00, 4'h5, 4'hA);
        row(16'h2A54, ST, 2'h0, 4'h4, 8'h00, 4'hA, 4'h5);
        row(16'h2A55, ST, 2'h1, 4'h4, 8'h00, 4'hA, 4'h5);
        row(16'h2A56, ST, 2'h2, 4'h4, 8'h00, 4'hA, 4'h5);
        check("pre dec base", 32'(uop.base), 32'(dtd_pkg::DTD_BASE_DEST));
        row(16'h80A3, ST, 2'h0, 4'h0, 8'h03, 4'hA, 4'h0);
        row(16'h81A3, ST, 2'h1, 4'h0, 8'h06, 4'hA, 4'h0);
        row(16'h84A3, LD, 2'h0, 4'h8, 8'h03, 4'hA, 4'h0);
        row(16'h85A3, LD, 2'h1, 4'h8, 8'h06, 4'hA, 4'h0);
        check("disp load base", 32'(uop.base), 32'(dtd_pkg::DTD_BASE_SRC));
        row(16'h1A5F, ST, 2'h2, 4'h0, 8'h3C, 4'hA, 4'h5);
        row(16'h5A5F, LD, 2'h2, 4'h0, 8'h3C, 4'h5, 4'hA);
        row(16'h0A54, ST, 2'h0, 4'h1, 8'h00, 4'hA, 4'h5);
        row(16'h0A55, ST, 2'h1, 4'h1, 8'h00, 4'hA, 4'h5);
        check("index base", 32'(uop.base), 32'(dtd_pkg::DTD_BASE_IDX));
        go(16'h6F03, 0, 0);
        check("move op", 32'(uop.op), 32'(dtd_pkg::DTD_OP_MOVE));
        check("move regs", {24'h0, uop.dest_reg, uop.source_reg}, 32'h000000F0);
        go(16'h2A57, 0, 0);
        check("illegal", 32'({uop.illegal, uop.op}), 32'h8);
    endtask

    // A store of the register just loaded costs one bubble; an unrelated store none
    task automatic t_hazard();
        go(16'h6012, 0, 0);
        go(16'h2102, 0, 0);
        check("hazard wait", 32'(waits), 32'h2);
        check("hazard stall", 32'(stalled), 32'h1);
        go(16'h6312, 0, 0);
        go(16'h2452, 0, 0);
        check("free wait", 32'(waits), 32'h1);
        go(16'h6722, 0, 0);
        go(16'h6573, 0, 0);
        check("move use wait", 32'(waits), 32'h2);
    endtask

    // Fetch holding memory delays a store but not an immediate; a busy execute stage holds all
    task automatic t_contention();
        go(16'h1A5F, 3, 0);
        check("busy wait", 32'(waits), 32'h4);
        check("busy stall", 32'(stalled), 32'h1);
        go(16'hE123, 3, 0);
        check("imm busy wait", 32'(waits), 32'h1);
        go(16'h5A5F, 0, 2);
        check("exec hold wait", 32'(waits), 32'h3);
    endtask

    // Ceiling far above the roughly fifty cycles the scenarios need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors = num_errors + 1;
            wrap_up();
        end
    end

    initial begin
        reset_n = 1'b0;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        t_immediate();
        t_pc();
        t_forms();
        t_hazard();
        t_contention();
        dtd_fetch_model_i.idle();
        check("flag outs", 32'({tflag_write, priv_required}), 32'h0);
        wrap_up();
    end
endmodule // dtd_decoder_test
